// ### core/fpexc_pkg.sv
// Constants and types shared by the floating-point arithmetic exception unit.
// Assumes a 32-bit APB register port and an 80-bit extended internal format.
package fpexc_pkg;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;

  // Field positions; the flag and mask fields are shared by control and status words
  localparam int ZBIT   = 2;   // Divide-by-zero flag and mask
  localparam int OBIT   = 3;   // Overflow flag and mask
  localparam int UBIT   = 4;   // Underflow flag and mask
  localparam int PBIT   = 5;   // Inexact flag and mask
  localparam int ESBIT  = 7;   // Exception summary, status word
  localparam int C1BIT  = 9;   // Round-up condition bit, status word
  localparam int RC_LSB = 10;  // Rounding control, control word

  // Reset values: all four exceptions masked, round to nearest
  localparam logic [15:0] CTRL_RST = 16'h037F;
  localparam logic [15:0] STAT_RST = 16'h0000;
  // Writable control bits and clearable status bits
  localparam logic [15:0] CTRL_WMASK = 16'h0F3F;
  localparam logic [15:0] STAT_W1C   = 16'h00BC;

  // Exponent figures, unbiased, signed 18-bit
  localparam logic signed [17:0] EXT_BIAS   = 18'sh03FFF;
  localparam logic signed [17:0] SCALE_BIAS = 18'sh06000;
  localparam logic signed [17:0] SGL_EMAX   = 18'sh0007F;
  localparam logic signed [17:0] DBL_EMAX   = 18'sh003FF;
  localparam logic signed [17:0] EXT_EMAX   = 18'sh03FFF;

  // Special encodings
  localparam logic [14:0] EXP_ONES = 15'h7FFF;
  localparam logic [63:0] SIG_INF  = 64'h8000000000000000;
  localparam logic [63:0] SIG_SGL  = 64'hFFFFFF0000000000;
  localparam logic [63:0] SIG_DBL  = 64'hFFFFFFFFFFFFF800;
  localparam logic [63:0] SIG_EXT  = 64'hFFFFFFFFFFFFFFFF;

  // Operation class presented by the datapath
  typedef enum logic [3:0] {
    OP_OTHER, OP_DIV, OP_RDIV, OP_IDIV, OP_LOGMUL,
    OP_EXTRACT, OP_SCALE, OP_FSTORE, OP_ISTORE
  } fpexc_op_t;

  // Destination format
  typedef enum logic [1:0] {FMT_SGL, FMT_DBL, FMT_EXT} fpexc_fmt_t;

  // Rounding control codes
  typedef enum logic [1:0] {RC_NEAR, RC_DOWN, RC_UP, RC_CHOP} fpexc_rc_t;

endpackage

// ### core/fpexc_unit.sv
// Exception detection and response for divide-by-zero, overflow,
// underflow and inexact results, with control and status words on APB.
// Assumes the datapath presents one rounded result per op_valid pulse.
//
// Notes on behaviour
// - Finite nonzero over zero raises divide-by-zero.
// - Divide-by-zero flag and mask at bit 2.
// - Only divides, log-multiply, extract report it.
// - Unmasked: flag, request handler, no writes.
// - Masked divide: infinity, sign is XOR.
// - Masked log-multiply: infinity, opposite sign.
// - Masked extract: second -inf, top signed zero.
// - Overflow above format maximum; integer stores excluded.
// - Overflow flag and mask at bit 3.
// - Masked overflow: default chosen by rounding control.
// - Unmasked memory over/underflow: no write, request.
// - Unmasked register overflow: scale down, store, request.
// - Unmasked register underflow: scale up, store, request.
// - Biased result sets round-up bit from rounding.
// - Scale recurring overflow infinity, underflow zero.
// - Underflow below normal minimum; never integer stores.
// - Underflow flag and mask at bit 4.
// - Inexact flag and mask at bit 5.
// - Inexact sets flag, round-up bit from rounding.
// - Unmasked inexact alone also requests handler.
// - Inexact with over/underflow sets both flags.
// - Memory fault hides inexact, clears round-up bit.
// - Pending request recorded in summary flag.
`timescale 1ns/1ps

module fpexc_unit #(
  parameter int ADDR_W = 12  // APB address width
) (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     srst,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [ADDR_W-1:0]        paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Operation from the datapath
  input  wire logic                     op_valid,
  input  wire fpexc_pkg::fpexc_op_t     op_class,
  input  wire fpexc_pkg::fpexc_fmt_t    dest_fmt,
  input  wire logic                     dest_mem,
  input  wire logic                     a_sign,
  input  wire logic                     a_zero,
  input  wire logic                     a_finite,
  input  wire logic                     b_sign,
  input  wire logic                     b_zero,
  input  wire logic                     res_sign,
  input  wire logic                     res_zero,
  input  wire logic signed [17:0]       res_exp,
  input  wire logic [63:0]              res_sig,
  input  wire logic                     res_inexact,
  input  wire logic                     res_rnd_up,
  // Result to the register stack or memory
  output logic                          res_write,
  output logic [79:0]                   res_val,
  output logic                          res2_write,
  output logic [79:0]                   res2_val,
  // Handler request to the core
  output logic                          exc_req
);

  // Control and status words
  logic [15:0]      ctrl_reg;        // Masks, precision, rounding
  logic [15:0]      stat_reg;        // Sticky flags, summary, round-up
  logic [15:0]      stat_next;       // Status after this cycle
  // Decoded control
  fpexc_pkg::fpexc_rc_t rc;          // Rounding mode
  logic             zm, om, um, pm;  // Masks
  // Detection
  logic             is_div;          // Any divide class
  logic             dz;              // Divide-by-zero seen
  logic             ovf, unf, inx;   // Overflow, underflow, inexact seen
  logic             mem_fault;       // Unmasked over/underflow to memory
  logic             req_next;        // Handler request this op
  logic             wr_next;         // Destination written
  logic             wr2_next;        // Second register written
  logic [79:0]      val_next;        // Destination value
  logic             c1_upd;          // Round-up bit updated
  logic             c1_val;          // Its new value
  logic signed [17:0] emax, emin;    // Destination exponent range
  logic signed [17:0] e_bias;        // Biased exponent
  // APB decode
  logic             acc, wr_en;
  logic             hit_ctrl, hit_stat;

  // Largest exponent of a destination format
  function automatic logic signed [17:0] f_emax(fpexc_pkg::fpexc_fmt_t f);
    unique case (f)
      fpexc_pkg::FMT_SGL: f_emax = fpexc_pkg::SGL_EMAX;
      fpexc_pkg::FMT_DBL: f_emax = fpexc_pkg::DBL_EMAX;
      default:            f_emax = fpexc_pkg::EXT_EMAX;
    endcase
  endfunction

  // Pack sign, unbiased exponent and significand into extended format
  function automatic logic [79:0] f_pack(logic s, logic signed [17:0] e,
                                         logic [63:0] m);
    logic signed [17:0] eb;
    eb = e + fpexc_pkg::EXT_BIAS;
    // Below range the datapath already delivered a denormal
    if (eb < 18'sd1) f_pack = {s, 15'h0000, m};
    else             f_pack = {s, eb[14:0], m};
  endfunction

  // Signed infinity
  function automatic logic [79:0] f_inf(logic s);
    f_inf = {s, fpexc_pkg::EXP_ONES, fpexc_pkg::SIG_INF};
  endfunction

  // Control field decode
  always_comb begin
    rc = fpexc_pkg::fpexc_rc_t'(ctrl_reg[fpexc_pkg::RC_LSB +: 2]);
    zm = ctrl_reg[fpexc_pkg::ZBIT];
    om = ctrl_reg[fpexc_pkg::OBIT];
    um = ctrl_reg[fpexc_pkg::UBIT];
    pm = ctrl_reg[fpexc_pkg::PBIT];
  end

  // Exception detection
  always_comb begin
    emax = f_emax(dest_fmt);
    emin = 18'sd1 - emax;
    is_div = (op_class == fpexc_pkg::OP_DIV) ||
             (op_class == fpexc_pkg::OP_RDIV) ||
             (op_class == fpexc_pkg::OP_IDIV);
    dz = op_valid && (
         ((is_div || op_class == fpexc_pkg::OP_LOGMUL)
           && b_zero && a_finite && !a_zero) ||
         (op_class == fpexc_pkg::OP_EXTRACT && b_zero));
    ovf = op_valid && !dz && !res_zero &&
          (op_class != fpexc_pkg::OP_ISTORE) && (res_exp > emax);
    unf = op_valid && !dz && !res_zero && !ovf &&
          (op_class != fpexc_pkg::OP_ISTORE) && (res_exp < emin);
    inx = op_valid && !dz && res_inexact;
    mem_fault = dest_mem && ((ovf && !om) || (unf && !um));
  end

  // Handler request and round-up bit
  always_comb begin
    req_next = (dz && !zm) || (ovf && !om) || (unf && !um) ||
               (inx && !pm && !mem_fault);
    c1_upd = ovf || unf || inx;
    c1_val = mem_fault ? 1'b0 : res_rnd_up;
  end

  // Result selection
  always_comb begin
    wr_next  = op_valid && !(dz && !zm) && !mem_fault;
    wr2_next = 1'b0;
    e_bias   = res_exp;
    val_next = res_zero ? {res_sign, 79'h0} : f_pack(res_sign, res_exp, res_sig);
    if (dz) begin
      if (op_class == fpexc_pkg::OP_EXTRACT) begin
        wr2_next = zm;
        val_next = {b_sign, 79'h0};
      end else if (op_class == fpexc_pkg::OP_LOGMUL) begin
        val_next = f_inf(!a_sign);
      end else begin
        val_next = f_inf(a_sign ^ b_sign);
      end
    end else if (ovf && om) begin
      if (rc == fpexc_pkg::RC_NEAR || (rc == fpexc_pkg::RC_DOWN && res_sign) ||
          (rc == fpexc_pkg::RC_UP && !res_sign)) begin
        val_next = f_inf(res_sign);
      end else begin
        unique case (dest_fmt)
          fpexc_pkg::FMT_SGL: val_next = f_pack(res_sign, emax, fpexc_pkg::SIG_SGL);
          fpexc_pkg::FMT_DBL: val_next = f_pack(res_sign, emax, fpexc_pkg::SIG_DBL);
          default:            val_next = f_pack(res_sign, emax, fpexc_pkg::SIG_EXT);
        endcase
      end
    end else if (ovf) begin
      e_bias = res_exp - fpexc_pkg::SCALE_BIAS;
      val_next = f_pack(res_sign, e_bias, res_sig);
      if (op_class == fpexc_pkg::OP_SCALE && e_bias > fpexc_pkg::EXT_EMAX) begin
        val_next = f_inf(res_sign);
      end
    end else if (unf && !um) begin
      e_bias = res_exp + fpexc_pkg::SCALE_BIAS;
      val_next = f_pack(res_sign, e_bias, res_sig);
      if (op_class == fpexc_pkg::OP_SCALE &&
          e_bias < 18'sd1 - fpexc_pkg::EXT_EMAX) begin
        val_next = {res_sign, 79'h0};
      end
    end
  end

  // APB decode; every access completes in one access cycle
  always_comb begin
    hit_ctrl = (paddr == fpexc_pkg::CTRL_OFS[ADDR_W-1:0]);
    hit_stat = (paddr == fpexc_pkg::STAT_OFS[ADDR_W-1:0]);
    acc      = psel && penable;
    wr_en    = acc && pwrite;
    pready   = 1'b1;
    pslverr  = acc && !hit_ctrl && !hit_stat;
  end

  // Control word: masks and rounding steer the response above
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_reg <= fpexc_pkg::CTRL_RST;
    end else if (wr_en && hit_ctrl) begin
      ctrl_reg <= pwdata[15:0] & fpexc_pkg::CTRL_WMASK;
    end
  end

  // Status next value; hardware set wins over software clear
  always_comb begin
    stat_next = stat_reg;
    if (wr_en && hit_stat) begin
      stat_next = stat_reg & ~(pwdata[15:0] & fpexc_pkg::STAT_W1C);
    end
    if (dz) stat_next[fpexc_pkg::ZBIT] = 1'b1;
    if (ovf) stat_next[fpexc_pkg::OBIT] = 1'b1;
    if (unf) stat_next[fpexc_pkg::UBIT] = 1'b1;
    if (inx && !mem_fault) stat_next[fpexc_pkg::PBIT] = 1'b1;
    if (req_next) stat_next[fpexc_pkg::ESBIT] = 1'b1;
    if (c1_upd) stat_next[fpexc_pkg::C1BIT] = c1_val;
  end

  // Status word register
  always_ff @(posedge mclk) begin
    if (srst) stat_reg <= fpexc_pkg::STAT_RST;
    else      stat_reg <= stat_next;
  end

  // Read data captured in the setup cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (hit_ctrl)      prdata <= {16'h0000, ctrl_reg};
      else if (hit_stat) prdata <= {16'h0000, stat_reg};
      else               prdata <= 32'h00000000;
    end
  end

  // Result and request outputs, registered
  always_ff @(posedge mclk) begin
    if (srst) begin
      res_write  <= 1'b0;
      res2_write <= 1'b0;
      res_val    <= 80'h0;
      res2_val   <= 80'h0;
      exc_req    <= 1'b0;
    end else begin
      res_write  <= wr_next;
      res2_write <= wr2_next;
      res_val    <= val_next;
      res2_val   <= f_inf(1'b1);
      exc_req    <= req_next;
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  property p_dz_flag;
    op_valid && is_div && b_zero && a_finite && !a_zero |=> stat_reg[2];
  endproperty
  a_dz_flag: assert property (p_dz_flag) else $error("dz flag not set");

  property p_dz_unmasked;
    dz && !zm |=> exc_req && !res_write && !res2_write;
  endproperty
  a_dz_unmasked: assert property (p_dz_unmasked) else $error("dz unmasked");

  property p_dz_sign;
    dz && zm && is_div |=> res_write && res_val[78:64] == 15'h7FFF &&
      res_val[79] == ($past(a_sign) ^ $past(b_sign));
  endproperty
  a_dz_sign: assert property (p_dz_sign) else $error("dz sign");

  property p_mem_fault;
    op_valid && dest_mem && ovf && !om |=> exc_req && !res_write;
  endproperty
  a_mem_fault: assert property (p_mem_fault) else $error("mem write");

  property p_ovf_bias;
    ovf && !om && !dest_mem && op_class != fpexc_pkg::OP_SCALE
      |=> res_val[78:64] == 15'($past(res_exp) - 18'sd8193);
  endproperty
  a_ovf_bias: assert property (p_ovf_bias) else $error("ovf bias");

  property p_c1_clr;
    mem_fault |=> !stat_reg[9] && !$rose(stat_reg[5]);
  endproperty
  a_c1_clr: assert property (p_c1_clr) else $error("c1 not cleared");

  property p_es;
    exc_req |-> stat_reg[7];
  endproperty
  a_es: assert property (p_es) else $error("summary missing");

  property p_istore;
    op_valid && op_class == fpexc_pkg::OP_ISTORE && !stat_reg[4] |=> !stat_reg[4];
  endproperty
  a_istore: assert property (p_istore) else $error("istore underflow");

  property p_ovf_flag;
    ovf ##1 (!wr_en || !hit_stat) |-> stat_reg[3] && $past(ovf);
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("ovf flag");

  property p_logmul_sign;
    dz && zm && op_class == fpexc_pkg::OP_LOGMUL |=> res_write &&
      res_val[78:64] == 15'h7FFF && res_val[79] == !$past(a_sign);
  endproperty
  a_logmul_sign: assert property (p_logmul_sign) else $error("logmul sign");

  property p_dz_extract;
    dz && zm && op_class == fpexc_pkg::OP_EXTRACT |=> res_write && res2_write &&
      res2_val == {1'b1, fpexc_pkg::EXP_ONES, fpexc_pkg::SIG_INF} &&
      res_val == {$past(b_sign), 79'h0};
  endproperty
  a_dz_extract: assert property (p_dz_extract) else $error("extract pair");

  property p_inx_req;
    inx && !pm && !mem_fault |=> exc_req && stat_reg[5] && stat_reg[7];
  endproperty
  a_inx_req: assert property (p_inx_req) else $error("inexact request");

  property p_c1_round;
    (ovf || unf || inx) && !mem_fault |=> stat_reg[9] == $past(res_rnd_up);
  endproperty
  a_c1_round: assert property (p_c1_round) else $error("round-up bit");

  property p_unf_flag;
    unf |=> stat_reg[4];
  endproperty
  a_unf_flag: assert property (p_unf_flag) else $error("unf flag");

endmodule // fpexc_unit

// ### verif/fpexc_core_model.sv
// Behavioural model of the core's exception request and write bookkeeping.
// Assumes results and requests arrive as registered one-cycle pulses.
`timescale 1ns/1ps

module fpexc_core_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // Unit outputs seen by the core
  input  wire logic        res_write,
  input  wire logic        exc_req,
  // Observed totals
  output logic [7:0]       trap_count,
  output logic [7:0]       write_count
);
  // pending trap
  // A request is only recorded here; the trap is taken at the next
  // waiting instruction, which this model does not sequence
  always_ff @(posedge mclk) begin
    if (srst) begin
      trap_count <= 8'h00;
    end else if (exc_req) begin
      trap_count <= trap_count + 8'h01;
    end
  end

  // Count destination writes for the bench's bookkeeping
  always_ff @(posedge mclk) begin
    if (srst) begin
      write_count <= 8'h00;
    end else if (res_write) begin
      write_count <= write_count + 8'h01;
    end
  end
endmodule // fpexc_core_model

// ### verif/tb_top.sv
// Self-checking bench for the arithmetic exception unit.
// Assumes zero-wait APB and results one cycle after op_valid.
`timescale 1ns/1ps

module tb_top;
  // Bench-driven inputs
  logic        mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic        op_valid = 0, dest_mem = 0, a_sign = 0, a_zero = 0, a_finite = 1;
  logic        b_sign = 0, b_zero = 0, res_sign = 0, res_zero = 0;
  logic        res_inexact = 0, res_rnd_up = 0;
  logic signed [17:0] res_exp = 0;
  logic [63:0] res_sig = 0;
  fpexc_pkg::fpexc_op_t  op_class = fpexc_pkg::OP_OTHER;
  fpexc_pkg::fpexc_fmt_t dest_fmt = fpexc_pkg::FMT_EXT;
  // Design outputs and bench working variables
  logic [31:0] prdata, rd;
  logic        pready, pslverr, res_write, res2_write, exc_req, er, sa, sb, mk;
  logic [79:0] res_val, res2_val;
  logic [7:0]  trap_count, exp_traps = 0, write_count, exp_writes = 0;
  logic [63:0] sig;
  int          failures = 0, samples_checked = 0;

  always #5 mclk = ~mclk;

  fpexc_unit u_fpexc_unit (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_valid(op_valid), .op_class(op_class), .dest_fmt(dest_fmt),
    .dest_mem(dest_mem), .a_sign(a_sign), .a_zero(a_zero), .a_finite(a_finite),
    .b_sign(b_sign), .b_zero(b_zero), .res_sign(res_sign), .res_zero(res_zero),
    .res_exp(res_exp), .res_sig(res_sig), .res_inexact(res_inexact),
    .res_rnd_up(res_rnd_up), .res_write(res_write), .res_val(res_val),
    .res2_write(res2_write), .res2_val(res2_val), .exc_req(exc_req));

  fpexc_core_model u_fpexc_core_model (.mclk(mclk), .srst(srst), .res_write(res_write),
    .exc_req(exc_req), .trap_count(trap_count), .write_count(write_count));

  // Extended encoding of an unbiased exponent
  function automatic logic [79:0] enc(logic s, logic signed [17:0] e, logic [63:0] g);
    logic signed [17:0] f;
    f = e + fpexc_pkg::EXT_BIAS;
    return {s, f[14:0], g};
  endfunction

  function automatic logic [79:0] inf(logic s);
    return {s, fpexc_pkg::EXP_ONES, fpexc_pkg::SIG_INF};
  endfunction

  // Masked overflow default: infinity unless rounding points inward
  function automatic logic [79:0] ovf_def(logic s, logic [1:0] rc);
    if (rc == 2'h0 || (rc == 2'h2 && !s) || (rc == 2'h1 && s)) begin
      return inf(s);
    end
    return {s, 15'h7FFE, fpexc_pkg::SIG_EXT};
  endfunction

  task automatic chk(input logic [79:0] seen, input logic [79:0] want, input string what);
    samples_checked++;
    if (seen !== want) begin
      failures++;
      $display("wrong value at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic test_done();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic ok;
    ok = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge mclk);
      ok = (pready === 1'b1);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (!ok) begin
      failures++;
      test_done();
    end
  endtask

  // Present one operation result for a single cycle
  task automatic run(input fpexc_pkg::fpexc_op_t c, input logic m, input logic s1, s2, bz,
                     input logic signed [17:0] e, input logic inx, up);
    sig = {1'b1, 31'($urandom), 32'($urandom)};
    @(posedge mclk);
    op_valid <= 1'b1;
    op_class <= c;
    dest_mem <= m;
    // Memory stores use double format for odd exponents, single otherwise
    dest_fmt <= m ? (e[0] ? fpexc_pkg::FMT_DBL : fpexc_pkg::FMT_SGL) : fpexc_pkg::FMT_EXT;
    a_sign <= s1;
    b_sign <= s2;
    res_sign <= s1;
    b_zero <= bz;
    res_exp <= e;
    res_sig <= sig;
    res_inexact <= inx;
    res_rnd_up <= up;
    @(posedge mclk);
    op_valid <= 1'b0;
    #1;
  endtask

  // Check outputs, then read the status word and clear its flags and summary
  task automatic verify(input logic w, input logic [79:0] v, input logic q,
                        input logic [31:0] st);
    chk(res_write, w, "res_write");
    if (w) chk(res_val, v, "res_val");
    chk(exc_req, q, "exc_req");
    exp_traps += q;
    exp_writes += w;
    apb(1'b0, fpexc_pkg::STAT_OFS, 0);
    chk(rd, st, "status");
    apb(1'b1, fpexc_pkg::STAT_OFS, 32'h000000BC);
  endtask

  initial begin
    #300us;
    failures++;
    test_done();
  end

  initial begin
    void'($urandom(28));
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    apb(1'b0, fpexc_pkg::CTRL_OFS, 0);
    chk(rd, 32'h037F, "ctrl reset");
    apb(1'b0, fpexc_pkg::STAT_OFS, 0);
    chk(rd, 32'h0, "stat reset");
    apb(1'b1, 12'h008, 32'hFFFFFFFF);
    chk(er, 1'b1, "unmapped");
    // Masked divide family, then log-multiply and extract
    for (int i = 1; i <= 3; i++) begin
      {sa, sb} = 2'($urandom);
      run(fpexc_pkg::fpexc_op_t'(i), 0, sa, sb, 1, 0, 0, 0);
      verify(1, inf(sa ^ sb), 0, 32'h04);
    end
    run(fpexc_pkg::OP_LOGMUL, 0, 1, 0, 1, 0, 0, 0);
    verify(1, inf(1'b0), 0, 32'h04);
    run(fpexc_pkg::OP_EXTRACT, 0, 0, 1, 1, 0, 0, 0);
    chk(res2_write, 1'b1, "second write");
    chk(res2_val, inf(1'b1), "second");
    verify(1, {1'b1, 79'h0}, 0, 32'h04);
    run(fpexc_pkg::OP_OTHER, 0, 0, 0, 1, 0, 0, 0);
    verify(1, enc(0, 0, sig), 0, 32'h0);
    chk(write_count, exp_writes, "write count");
    a_zero <= 1'b1;
    run(fpexc_pkg::OP_DIV, 0, 0, 0, 1, 0, 0, 0);
    a_zero <= 1'b0;
    chk(exc_req, 0, "zero over zero");
    apb(1'b0, fpexc_pkg::STAT_OFS, 0);
    chk(rd, 32'h0, "zero over zero flag");
    apb(1'b1, fpexc_pkg::STAT_OFS, 32'h000000BC);
    // Unmask everything, keep extended precision and nearest rounding
    apb(1'b1, fpexc_pkg::CTRL_OFS, 32'h00000300);
    run(fpexc_pkg::OP_DIV, 0, 0, 1, 1, 0, 0, 0);
    verify(0, 0, 1, 32'h84);
    run(fpexc_pkg::OP_OTHER, 0, 1, 0, 0, -18'sd16400, 1, 0);
    verify(1, enc(1, -18'sd16400 + fpexc_pkg::SCALE_BIAS, sig), 1, 32'hB0);
    run(fpexc_pkg::OP_OTHER, 0, 0, 0, 0, 18'sd16393, 1, 1);
    verify(1, enc(0, 18'sd16393 - fpexc_pkg::SCALE_BIAS, sig), 1, 32'h2A8);
    run(fpexc_pkg::OP_FSTORE, 1, 0, 0, 0, 18'sd200, 1, 1);
    verify(0, 0, 1, 32'h88);
    run(fpexc_pkg::OP_FSTORE, 1, 0, 0, 0, -18'sd200, 0, 0);
    verify(0, 0, 1, 32'h90);
    run(fpexc_pkg::OP_ISTORE, 1, 0, 0, 0, 18'sd200, 0, 0);
    chk(exc_req, 0, "integer store");
    apb(1'b0, fpexc_pkg::STAT_OFS, 0);
    chk(rd, 32'h0, "integer store");
    // Double-format stores: largest exponent passes, two above it faults
    run(fpexc_pkg::OP_FSTORE, 1, 0, 0, 0, 18'sd1023, 0, 0);
    verify(1, enc(0, 18'sd1023, sig), 0, 32'h0);
    run(fpexc_pkg::OP_FSTORE, 1, 0, 0, 0, 18'sd1025, 0, 0);
    verify(0, 0, 1, 32'h88);
    run(fpexc_pkg::OP_SCALE, 0, 1, 0, 0, 18'sd41059, 0, 0);
    verify(1, inf(1'b1), 1, 32'h88);
    run(fpexc_pkg::OP_SCALE, 0, 1, 0, 0, -18'sd41100, 0, 0);
    verify(1, {1'b1, 79'h0}, 1, 32'h90);
    run(fpexc_pkg::OP_OTHER, 0, 0, 0, 0, 0, 1, 1);
    verify(1, enc(0, 0, sig), 1, 32'h2A0);
    // Masked overflow under each rounding mode, with inexact
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, fpexc_pkg::CTRL_OFS, 32'h033F | (r << 10));
      sa = 1'($urandom);
      run(fpexc_pkg::OP_OTHER, 0, sa, 0, 0, 18'sd16500, 1, 0);
      verify(1, ovf_def(sa, 2'(r)), 0, 32'h28);
    end
    run(fpexc_pkg::OP_OTHER, 0, 0, 0, 0, 0, 1, 1);
    verify(1, enc(0, 0, sig), 0, 32'h220);
    // Random divides with random divide-by-zero mask
    for (int i = 0; i < 24; i++) begin
      {mk, sa, sb} = 3'($urandom);
      apb(1'b1, fpexc_pkg::CTRL_OFS, {29'h0, mk, 2'h3});
      run(fpexc_pkg::OP_RDIV, 0, sa, sb, 1, 0, 0, 0);
      // Round-up bit stays set from the last inexact case; divides leave it alone
      verify(mk, inf(sa ^ sb), !mk, mk ? 32'h204 : 32'h284);
    end
    chk(trap_count, exp_traps, "trap count");
    test_done();
  end
endmodule // tb_top
